// file: rtl/dcf_fifo_block.sv
// Operation
// - Three-bit width codes select five aspect ratios
// - Port works only while block enable low
// - Read block high holds read data
// - Enable polarities selectable, write low read high
// - Both ports run synchronous to the single sys_clk
// - Nonpipelined read presents data at once
// - Pipelined read presents data one cycle later
// - Reset clears control and output registers
// - Reset leaves memory array contents alone
// - Requests ignored while reset is asserted
// - Only selected low write bits are stored
// - Thresholds compared as counts of bits
// - Counters stop or run past limits
`timescale 1ns/100ps
module dcf_fifo_block
  import dcf_pkg::*;
#(
  parameter int BUF_DEPTH = STAGE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fifo_reset_n,
  input wire logic [CODE_W-1:0] write_width_sel,
  input wire logic [CODE_W-1:0] read_width_sel,
  input wire logic write_port_block_n,
  input wire logic read_port_block_n,
  input wire logic write_en,
  input wire logic read_en,
  input wire logic write_en_high_sel,
  input wire logic read_en_high_sel,
  input wire logic read_pipeline_sel,
  input wire logic counter_run_sel,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic [PTR_W-1:0] almost_full_bits,
  input wire logic [PTR_W-1:0] almost_empty_bits,
  output logic [DATA_W-1:0] read_data_out,
  output logic full,
  output logic almost_full,
  output logic empty,
  output logic almost_empty,
  output logic [CNT_W-1:0] write_count,
  output logic [CNT_W-1:0] read_count
);

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  logic clr;
  logic [BITS_W-1:0] wbits;
  logic wr_req;
  logic wr_ok;
  logic [DATA_W-1:0] wmask;
  logic st_in_ready;
  logic st_out_valid;
  logic [STAGE_W-1:0] st_out_data;
  logic [BITS_W-1:0] head_bits;
  logic drain;
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] next_wptr;
  logic [PTR_W-1:0] rgray_w;
  logic [PTR_W-1:0] wocc;
  logic [RING_BITS-1:0] mem;
  logic [RING_BITS-1:0] next_mem;

  assign clr = rst || !fifo_reset_n;

  always_comb begin
    wbits = width_bits(write_width_sel);
    wr_req = !clr && !write_port_block_n && (wbits != BITS_NONE)
      && (write_en_high_sel ? write_en : !write_en);
    wr_ok = wr_req && st_in_ready;
    wmask = '0;
    for (int i = 0; i < DATA_W; i++) begin
      wmask[i] = (i < int'(wbits));
    end
  end

  dcf_stage_fifo #(
    .WIDTH(STAGE_W),
    .DEPTH(BUF_DEPTH)
  ) u_stage (
    .sys_clk(sys_clk),
    .rst(clr),
    .in_valid(wr_req),
    .in_ready(st_in_ready),
    .in_data({write_width_sel, write_data_in & wmask}),
    .out_valid(st_out_valid),
    .out_ready(drain),
    .out_data(st_out_data)
  );

  always_comb begin
    logic [PTR_W-1:0] pos;
    pos = '0;
    head_bits = width_bits(st_out_data[STAGE_W-1:DATA_W]);
    wocc = wptr - gray2bin(rgray_w);
    drain = !clr && st_out_valid
      && ((RING_BITS - wocc) >= PTR_W'(head_bits));
    next_wptr = drain ? wptr + PTR_W'(head_bits) : wptr;
    next_mem = mem;
    for (int i = 0; i < DATA_W; i++) begin
      pos = wptr + PTR_W'(i);
      if (drain && (i < int'(head_bits))) begin
        next_mem[pos[RING_AW-1:0]] = st_out_data[i];
      end
    end
    if (clr) begin
      next_wptr = PTR_RST;
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  logic [BITS_W-1:0] rbits;
  logic rd_req;
  logic rd_ok;
  logic [PTR_W-1:0] rptr;
  logic [PTR_W-1:0] next_rptr;
  logic [PTR_W-1:0] wgray_r;
  logic [PTR_W-1:0] ravail;
  logic [DATA_W-1:0] fetched;
  logic [DATA_W-1:0] pipe_data;
  logic [DATA_W-1:0] next_pipe_data;
  logic [DATA_W-1:0] next_read_data_out;

  always_comb begin
    logic [PTR_W-1:0] pos;
    pos = '0;
    rbits = width_bits(read_width_sel);
    ravail = gray2bin(wgray_r) - rptr;
    rd_req = !clr && !read_port_block_n && (rbits != BITS_NONE)
      && (read_en_high_sel ? read_en : !read_en);
    rd_ok = rd_req && (ravail >= PTR_W'(rbits));
    fetched = '0;
    for (int i = 0; i < DATA_W; i++) begin
      pos = rptr + PTR_W'(i);
      if (i < int'(rbits)) begin
        fetched[i] = mem[pos[RING_AW-1:0]];
      end
    end
    next_rptr = rd_ok ? rptr + PTR_W'(rbits) : rptr;
    next_pipe_data = rd_ok ? fetched : pipe_data;
    next_read_data_out = read_data_out;
    if (!read_port_block_n) begin
      if (read_pipeline_sel) begin
        next_read_data_out = pipe_data;
      end else if (rd_ok) begin
        next_read_data_out = fetched;
      end
    end
    if (clr) begin
      next_rptr = PTR_RST;
      next_pipe_data = DATA_RST;
      next_read_data_out = DATA_RST;
    end
  end

  // ----------------------------------------------------------------
  // Pointer crossing
  // ----------------------------------------------------------------
  dcf_sync #(
    .W(PTR_W)
  ) u_rsync (
    .sys_clk(sys_clk),
    .rst(clr),
    .d(bin2gray(rptr)),
    .q(rgray_w)
  );

  dcf_sync #(
    .W(PTR_W)
  ) u_wsync (
    .sys_clk(sys_clk),
    .rst(clr),
    .d(bin2gray(wptr)),
    .q(wgray_r)
  );

  // ----------------------------------------------------------------
  // Flags and counters
  // ----------------------------------------------------------------
  logic next_full;
  logic next_almost_full;
  logic next_empty;
  logic next_almost_empty;
  logic [CNT_W-1:0] next_write_count;
  logic [CNT_W-1:0] next_read_count;
  logic wr_step;
  logic rd_step;

  always_comb begin
    wr_step = wr_ok || (counter_run_sel && wr_req);
    rd_step = rd_ok || (counter_run_sel && rd_req);
    next_write_count = write_count + CNT_W'(wr_step);
    next_read_count = read_count + CNT_W'(rd_step);
    next_full = !st_in_ready;
    next_almost_full = (wocc >= almost_full_bits);
    next_empty = (ravail < PTR_W'(rbits));
    next_almost_empty = (ravail <= almost_empty_bits);
    if (clr) begin
      next_write_count = CNT_RST;
      next_read_count = CNT_RST;
      next_full = 1'b0;
      next_almost_full = 1'b0;
      next_empty = 1'b1;
      next_almost_empty = 1'b1;
    end
  end

  // One clock serves both ports in this build
  always_ff @(posedge sys_clk) begin
    wptr <= next_wptr;
    rptr <= next_rptr;
    pipe_data <= next_pipe_data;
    read_data_out <= next_read_data_out;
    full <= next_full;
    almost_full <= next_almost_full;
    empty <= next_empty;
    almost_empty <= next_almost_empty;
    write_count <= next_write_count;
    read_count <= next_read_count;
  end

  // Array has no reset so contents survive a clear
  always_ff @(posedge sys_clk) begin
    mem <= next_mem;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pipe_read;
    rd_ok && read_pipeline_sel ##1 !read_port_block_n && !clr
      && read_pipeline_sel;
  endsequence

  a_read_port_block_n_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    read_port_block_n && !clr |=> $stable(read_data_out))
    else $error("Read data changed while port blocked");
  a_reset_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    !fifo_reset_n |=> read_data_out == '0 && write_count == '0)
    else $error("Reset did not clear outputs");
  a_reset_flags: assert property (
    @(posedge sys_clk) disable iff (rst)
    clr |=> empty && almost_empty && !full && !almost_full)
    else $error("Reset did not clear flags");
  a_reset_no_step: assert property (
    @(posedge sys_clk) disable iff (rst)
    !fifo_reset_n ##1 !fifo_reset_n |-> wptr == '0 && rptr == '0)
    else $error("Pointers moved during reset");
  a_nonpipe_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    rd_ok && !read_pipeline_sel |=> read_data_out == $past(fetched))
    else $error("Nonpipelined data late");
  a_pipe_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_pipe_read |=> read_data_out == $past(fetched, 2))
    else $error("Pipelined data not one cycle later");
  a_empty_ignore: assert property (
    @(posedge sys_clk) disable iff (rst)
    rd_req && !rd_ok |=> rptr == $past(rptr))
    else $error("Read while empty moved pointer");
  a_write_port_block_n_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    write_port_block_n && !clr |=> write_count == $past(write_count))
    else $error("Blocked write port counted");
  a_wen_polarity: assert property (
    @(posedge sys_clk) disable iff (rst)
    !write_en_high_sel && write_en && !clr |=> $stable(write_count))
    else $error("Inactive low write enable counted");
  a_wr_reserved: assert property (
    @(posedge sys_clk) disable iff (rst)
    !clr && write_width_sel > WIDTH_X18 |=> $stable(write_count))
    else $error("Reserved write width accepted");
  a_drain_bits: assert property (
    @(posedge sys_clk) disable iff (rst)
    drain |=> wptr == $past(wptr) + PTR_W'($past(head_bits)))
    else $error("Write pointer step wrong");
  a_run_count: assert property (
    @(posedge sys_clk) disable iff (rst)
    counter_run_sel && wr_req && !st_in_ready
      |=> write_count == $past(write_count) + 1'b1)
    else $error("Counter stopped in run mode");
  a_wcount_stop: assert property (
    @(posedge sys_clk) disable iff (rst)
    !counter_run_sel && wr_req && !st_in_ready |=> $stable(write_count))
    else $error("Write counter ran in stop mode");
  a_rcount_run: assert property (
    @(posedge sys_clk) disable iff (rst)
    counter_run_sel && rd_req && !rd_ok
      |=> read_count == $past(read_count) + 1'b1)
    else $error("Read counter stopped in run mode");
  a_rcount_stop: assert property (
    @(posedge sys_clk) disable iff (rst)
    !counter_run_sel && rd_req && !rd_ok |=> $stable(read_count))
    else $error("Read counter ran in stop mode");
  a_afull_bits: assert property (
    @(posedge sys_clk) disable iff (rst)
    !clr |=> almost_full == ($past(wocc) >= $past(almost_full_bits)))
    else $error("Almost full not bit based");

endmodule

// file: rtl/dcf_pkg.sv
package dcf_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int CODE_W = 3;
  localparam int BITS_W = 5;
  localparam int RING_AW = 12;
  localparam int PTR_W = RING_AW + 1;
  localparam int CNT_W = 16;
  localparam int STAGE_DEPTH = 16;
  localparam int STAGE_W = DATA_W + CODE_W;
  localparam logic [PTR_W-1:0] RING_BITS = 13'h1000;

  // ----------------------------------------------------------------
  // Aspect-ratio codes and their widths in bits
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] WIDTH_X1 = 3'h0;
  localparam logic [CODE_W-1:0] WIDTH_X2 = 3'h1;
  localparam logic [CODE_W-1:0] WIDTH_X4 = 3'h2;
  localparam logic [CODE_W-1:0] WIDTH_X9 = 3'h3;
  localparam logic [CODE_W-1:0] WIDTH_X18 = 3'h4;
  localparam logic [BITS_W-1:0] BITS_X1 = 5'h01;
  localparam logic [BITS_W-1:0] BITS_X2 = 5'h02;
  localparam logic [BITS_W-1:0] BITS_X4 = 5'h04;
  localparam logic [BITS_W-1:0] BITS_X9 = 5'h09;
  localparam logic [BITS_W-1:0] BITS_X18 = 5'h12;
  localparam logic [BITS_W-1:0] BITS_NONE = 5'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
  localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  function automatic logic [BITS_W-1:0] width_bits(
    input logic [CODE_W-1:0] code
  );
    case (code)
      WIDTH_X1: width_bits = BITS_X1;
      WIDTH_X2: width_bits = BITS_X2;
      WIDTH_X4: width_bits = BITS_X4;
      WIDTH_X9: width_bits = BITS_X9;
      WIDTH_X18: width_bits = BITS_X18;
      default: width_bits = BITS_NONE;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

endpackage

// file: rtl/dcf_sync.sv
`timescale 1ns/100ps
module dcf_sync
  import dcf_pkg::*;
#(
  parameter int W = PTR_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = rst ? '0 : d;
    next_q = rst ? '0 : meta;
  end

  always_ff @(posedge sys_clk) begin
    meta <= next_meta;
    q <= next_q;
  end

endmodule

// file: rtl/dcf_stage_fifo.sv
`timescale 1ns/100ps
module dcf_stage_fifo
  import dcf_pkg::*;
#(
  parameter int WIDTH = STAGE_W,
  parameter int DEPTH = STAGE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_idx;
  logic [AW-1:0] next_rd_idx;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    in_ready = (count != (AW+1)'(DEPTH));
    out_valid = (count != '0);
    out_data = store[rd_idx];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
    next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    if (rst) begin
      next_wr_idx = '0;
      next_rd_idx = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    wr_idx <= next_wr_idx;
    rd_idx <= next_rd_idx;
    count <= next_count;
    if (push) begin
      store[wr_idx] <= in_data;
    end
  end

endmodule

// file: testbench/dcf_core_model.sv
`timescale 1ns/100ps
module dcf_core_model
  import dcf_pkg::*;
(
  input wire logic push,
  input wire logic pop,
  input wire logic wr_blk,
  input wire logic rd_blk,
  input wire logic [DATA_W-1:0] push_word,
  input wire logic [CODE_W-1:0] write_width_sel,
  input wire logic write_en_high_sel,
  input wire logic read_en_high_sel,
  output logic write_port_block_n,
  output logic read_port_block_n,
  output logic write_en,
  output logic read_en,
  output logic [DATA_W-1:0] write_data_in
);
  logic [DATA_W-1:0] mask;

  always_comb begin
    case (write_width_sel)
      3'h0: mask = 18'h0_0001;
      3'h1: mask = 18'h0_0003;
      3'h2: mask = 18'h0_000F;
      3'h3: mask = 18'h0_01FF;
      default: mask = 18'h3_FFFF;
    endcase
  end

  assign write_port_block_n = ~push | wr_blk;
  // Read port stays enabled between reads so a pipelined word can emerge
  assign read_port_block_n = rd_blk;
  assign write_en = write_en_high_sel ? push : ~push;
  assign read_en = read_en_high_sel ? pop : ~pop;
  // Idle data is the inverse of the last word, upper bits kept low
  assign write_data_in = mask & (push ? push_word : ~push_word);
endmodule

// file: testbench/dcf_fifo_block_tb.sv
`timescale 1ns/100ps
module dcf_fifo_block_tb
  import dcf_pkg::*;
;
  localparam int WT[5] = '{1, 2, 4, 9, 18};
  logic sys_clk, rst, fifo_reset_n, push, pop, wr_blk, rd_blk;
  logic write_en_high_sel, read_en_high_sel, read_pipeline_sel;
  logic counter_run_sel;
  logic [CODE_W-1:0] write_width_sel, read_width_sel;
  logic [DATA_W-1:0] push_word, write_data_in, read_data_out;
  logic [PTR_W-1:0] almost_full_bits, almost_empty_bits;
  logic write_port_block_n, read_port_block_n, write_en, read_en;
  logic full, almost_full, empty, almost_empty;
  logic [CNT_W-1:0] write_count, read_count, wc0;
  int num_errors, compares, n;

  dcf_core_model dcf_core_model_inst (
    .push(push), .pop(pop), .wr_blk(wr_blk), .rd_blk(rd_blk),
    .push_word(push_word), .write_width_sel(write_width_sel),
    .write_en_high_sel(write_en_high_sel),
    .read_en_high_sel(read_en_high_sel),
    .write_port_block_n(write_port_block_n),
    .read_port_block_n(read_port_block_n),
    .write_en(write_en), .read_en(read_en),
    .write_data_in(write_data_in)
  );
  dcf_fifo_block dcf_fifo_block_inst (
    .sys_clk(sys_clk), .rst(rst), .fifo_reset_n(fifo_reset_n),
    .write_width_sel(write_width_sel), .read_width_sel(read_width_sel),
    .write_port_block_n(write_port_block_n),
    .read_port_block_n(read_port_block_n),
    .write_en(write_en), .read_en(read_en),
    .write_en_high_sel(write_en_high_sel),
    .read_en_high_sel(read_en_high_sel),
    .read_pipeline_sel(read_pipeline_sel),
    .counter_run_sel(counter_run_sel), .write_data_in(write_data_in),
    .almost_full_bits(almost_full_bits),
    .almost_empty_bits(almost_empty_bits),
    .read_data_out(read_data_out), .full(full),
    .almost_full(almost_full), .empty(empty),
    .almost_empty(almost_empty), .write_count(write_count),
    .read_count(read_count)
  );

  // ----
  // Helpers
  // ----
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [DATA_W-1:0] w);
    push = 1'b1;
    push_word = w;
    @(negedge sys_clk);
  endtask

  task automatic idle(input int k);
    push = 1'b0;
    pop = 1'b0;
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [DATA_W-1:0] e);
    pop = 1'b1;
    @(negedge sys_clk);
    check(read_data_out, e);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic s_basic;
    wr(18'h1_2345);
    wr(18'h2_ABCD);
    wr(18'h3_0F0F);
    idle(6);
    check(write_count, 18'h0_0003);
    rd(18'h1_2345);
    rd(18'h2_ABCD);
    idle(1);
    read_pipeline_sel = 1'b1;
    pop = 1'b1;
    @(negedge sys_clk);
    pop = 1'b0;
    check(read_data_out, 18'h2_ABCD);
    @(negedge sys_clk);
    check(read_data_out, 18'h3_0F0F);
    read_pipeline_sel = 1'b0;
    rd(18'h3_0F0F);
    idle(1);
    check(read_count, 18'h0_0003);
    counter_run_sel = 1'b1;
    rd(18'h3_0F0F);
    idle(1);
    counter_run_sel = 1'b0;
    check(read_count, 18'h0_0004);
  endtask

  task automatic s_block;
    wr_blk = 1'b1;
    wr(18'h0_1111);
    idle(1);
    wr_blk = 1'b0;
    check(write_count, 18'h0_0003);
    wr(18'h0_2222);
    idle(6);
    rd_blk = 1'b1;
    rd(18'h3_0F0F);
    idle(1);
    rd_blk = 1'b0;
    check(read_count, 18'h0_0004);
    rd(18'h0_2222);
    idle(1);
  endtask

  task automatic s_pol;
    write_en_high_sel = 1'b1;
    read_en_high_sel = 1'b0;
    wr(18'h3_C3C3);
    idle(6);
    rd(18'h3_C3C3);
    idle(1);
    write_en_high_sel = 1'b0;
    read_en_high_sel = 1'b1;
  endtask

  task automatic s_width;
    read_width_sel = WIDTH_X1;
    for (int c = 0; c < 5; c++) begin
      write_width_sel = c[2:0];
      wr(18'h2_D3B5);
      idle(6);
      for (int i = 0; i < WT[c]; i++)
        rd({17'h0_0000, push_word[i]});
      idle(1);
    end
    write_width_sel = 3'h5;
    wc0 = write_count;
    wr(18'h2_D3B5);
    idle(2);
    check(write_count, wc0);
    write_width_sel = WIDTH_X18;
    read_width_sel = WIDTH_X18;
  endtask

  task automatic s_fill;
    int k;
    k = 0;
    wc0 = write_count;
    while (full !== 1'b1 && k < 400) begin
      wr(k[17:0]);
      k++;
    end
    idle(2);
    if (k == 400) begin
      num_errors++;
      wrap_up;
    end
    check(full, 18'h0_0001);
    check(almost_full, 18'h0_0001);
    n = int'(write_count - wc0);
    wc0 = write_count;
    wr(18'h3_FFFF);
    idle(2);
    check(write_count, wc0);
    counter_run_sel = 1'b1;
    wr(18'h3_FFFF);
    idle(2);
    counter_run_sel = 1'b0;
    check(write_count, wc0 + 16'h0001);
    for (int j = 0; j < n; j++)
      rd(j[17:0]);
    idle(6);
    check(empty, 18'h0_0001);
    check(almost_empty, 18'h0_0001);
  endtask

  task automatic s_reset;
    wr(18'h0_7777);
    idle(6);
    rd(18'h0_7777);
    idle(1);
    fifo_reset_n = 1'b0;
    wr(18'h0_5555);
    idle(2);
    check(read_data_out, 18'h0_0000);
    check(write_count, 18'h0_0000);
    check(empty, 18'h0_0001);
    fifo_reset_n = 1'b1;
    idle(6);
    check(empty, 18'h0_0001);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    {rst, fifo_reset_n, read_en_high_sel} = 3'h7;
    {push, pop, wr_blk, rd_blk, write_en_high_sel} = 5'h00;
    {read_pipeline_sel, counter_run_sel} = 2'h0;
    push_word = 18'h0_0000;
    write_width_sel = WIDTH_X18;
    read_width_sel = WIDTH_X18;
    almost_full_bits = 13'h0900;
    almost_empty_bits = 13'h0012;
    num_errors = 0;
    compares = 0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check(read_data_out, 18'h0_0000);
    check(almost_full, 18'h0_0000);
    s_basic;
    s_block;
    s_pol;
    s_width;
    s_fill;
    s_reset;
    wrap_up;
  end
endmodule
